//--- rtl/bte_pkg.sv
// Package for the branch trace buffer encoder: entry codes, field layout, structs.
// Assumes one processor clock; the core presents retirement events one at a time.
package bte_pkg;
  // ==========================================================================
  // Entry layout
  localparam int ENTRY_W = 6;
  localparam int ENTRY_DATA_BIT = 5;
  localparam int ENTRY_RW_BIT = 4;
  localparam logic [1:0] ADDR_PREFIX = 2'h2;
  // ==========================================================================
  // Status codes
  localparam logic [4:0] ST_INSN = 5'h01;
  localparam logic [4:0] ST_TAKEN = 5'h05;
  localparam logic [4:0] ST_OPND_1B = 5'h08;
  localparam logic [4:0] ST_OPND_2B = 5'h09;
  localparam logic [4:0] ST_OPND_4B = 5'h0B;
  localparam logic [4:0] ST_ADDR_2B = 5'h0D;
  localparam logic [4:0] ST_ADDR_3B = 5'h0E;
  localparam logic [4:0] ST_EXCP = 5'h1C;
  localparam logic [1:0] EXCP_COPIES = 2'h2;
  // ==========================================================================
  // Operand sizes as a byte-count code
  typedef enum logic [1:0] {
    BTE_SZ_1 = 2'h0,
    BTE_SZ_2 = 2'h1,
    BTE_SZ_4 = 2'h2
  } bte_size_t;
  // Retirement event from the core
  typedef struct packed {
    logic taken;         // Branch taken
    logic variant;       // Variant-address branch (exception vectors come on excp_vector, not here)
    logic opnd_valid;    // Memory operand present
    logic opnd_write;    // Operand was written
    bte_size_t opnd_size;
    logic [31:0] opnd_data;
    logic [23:0] target;
  } bte_event_t;
  // Configuration from the debug config/status bits
  typedef struct packed {
    logic trace_rd;      // Trace read operands
    logic trace_wr;      // Trace write operands
    logic tgt_en;        // Capture branch targets
    logic tgt_3byte;     // 3 address bytes instead of 2
  } bte_cfg_t;
endpackage : bte_pkg

//--- rtl/bte_entry_fmt.sv
// Entry formatter: builds one 6-bit trace entry from its kind and payload.
// Assumes the caller presents well-formed kinds; purely combinational.
module bte_entry_fmt (
  input wire logic [1:0] kind,
  input wire logic [4:0] payload,
  output logic [bte_pkg::ENTRY_W-1:0] entry
);
  import bte_pkg::*;
  // ==========================================================================
  // Kind 0 status, 1 data, 2 address
  always_comb begin
    case (kind)
      2'h0: entry = {1'b0, payload};
      2'h1: entry = {1'b1, payload[4], payload[3:0]};
      2'h2: entry = {ADDR_PREFIX, payload[3:0]};
      default: entry = {1'b0, payload};
    endcase
  end
endmodule // bte_entry_fmt

//--- rtl/bte_encoder.sv
// Trace encoder: turns core retirement and exception events into 6-bit entries.
// Assumes the core holds ev_valid/excp until ev_ready; buffer accepts an entry each cycle.
//
// Operation
// - A taken branch emits status entry 0x05.
// - Target capture order: 0x05, then size marker, then address entries.
// - Marker is 0x0D for 2 address bytes, 0x0E for 3, per config.
// - Targets captured only for variant-address branches and exception vectors.
// - Multi-entry values go out least significant part first.
// - Address entries carry prefix 10 over one nibble, lowest nibble first.
// - Entries are 6 bits: status has bit5 clear, data has bit5 set plus r/w.
// - Emitted target address is the address shifted right by one.
// - Traced byte operand: marker 08 then two data entries, write sets r/w.
// - Interrupt: exception entries, 0x05, marker, then handler address nibbles.
// - Each completed non-taken instruction emits 0x01, optionally 08/09/0B with operand.
// - Entries are written to consecutive buffer slots in generation order.
// - At most two 0x1C entries per exception, then suppressed.
module bte_encoder (
  input wire logic clk,
  input wire logic resetn,
  input wire bte_pkg::bte_cfg_t cfg,
  input wire logic ev_valid,
  input wire bte_pkg::bte_event_t ev,
  input wire logic excp,
  input wire logic [23:0] excp_vector,
  output logic ev_ready,
  output logic [bte_pkg::ENTRY_W-1:0] entry_data_ff,
  output logic entry_valid_ff
);
  import bte_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_MARK = 5'b00010,
    S_DATA = 5'b00100,
    S_AMRK = 5'b01000,
    S_ADDR = 5'b10000
  } bte_state_t;

  bte_state_t state_ff;
  logic [31:0] opnd_ff;
  logic opnd_wr_ff;
  logic [3:0] data_left_ff;
  logic [22:0] addr_ff;
  logic [2:0] addr_left_ff;
  logic do_addr_ff;
  logic [1:0] excp_cnt_ff;
  logic [1:0] fmt_kind;
  logic [4:0] fmt_payload;
  logic [ENTRY_W-1:0] fmt_entry;
  logic want_opnd;
  logic want_tgt;

  // ==========================================================================
  // Decisions for the presented event
  function automatic logic [4:0] size_marker(input bte_size_t sz);
    case (sz)
      BTE_SZ_1: size_marker = ST_OPND_1B;
      BTE_SZ_2: size_marker = ST_OPND_2B;
      default: size_marker = ST_OPND_4B;
    endcase
  endfunction

  function automatic logic [3:0] size_nibbles(input bte_size_t sz);
    case (sz)
      BTE_SZ_1: size_nibbles = 4'h2;
      BTE_SZ_2: size_nibbles = 4'h4;
      default: size_nibbles = 4'h8;
    endcase
  endfunction

  assign want_opnd = ev.opnd_valid && (ev.opnd_write ? cfg.trace_wr : cfg.trace_rd);
  assign want_tgt = cfg.tgt_en && ev.variant;

  // Idle only; an exception, or the vector branch it still owes, holds the core off
  // so that no event is handshaken in the cycle the vector branch is issued
  assign ev_ready = (state_ff == S_IDLE) && !excp && (excp_cnt_ff == 2'h0);

  // ==========================================================================
  // Sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= S_IDLE;
      opnd_ff <= 32'h0000_0000;
      opnd_wr_ff <= 1'b0;
      data_left_ff <= 4'h0;
      addr_ff <= 23'h00_0000;
      addr_left_ff <= 3'h0;
      do_addr_ff <= 1'b0;
      fmt_kind <= 2'h0;
      fmt_payload <= 5'h00;
      entry_valid_ff <= 1'b0;
    end else begin
      entry_valid_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (excp) begin
            // Exception copies are emitted here; the counter process below counts them
            if (excp_cnt_ff < EXCP_COPIES) begin
              fmt_kind <= 2'h0;
              fmt_payload <= ST_EXCP;
              entry_valid_ff <= 1'b1;
            end
          end else if (excp_cnt_ff != 2'h0 && !excp) begin
            // Exception done: taken-branch to the vector
            fmt_kind <= 2'h0;
            fmt_payload <= ST_TAKEN;
            entry_valid_ff <= 1'b1;
            addr_ff <= excp_vector[23:1];
            do_addr_ff <= 1'b0;
            state_ff <= cfg.tgt_en ? S_AMRK : S_IDLE;
          end else if (ev_valid) begin
            fmt_kind <= 2'h0;
            fmt_payload <= ev.taken ? ST_TAKEN : ST_INSN;
            entry_valid_ff <= 1'b1;
            opnd_ff <= ev.opnd_data;
            opnd_wr_ff <= ev.opnd_write;
            data_left_ff <= size_nibbles(ev.opnd_size);
            addr_ff <= ev.target[23:1];
            do_addr_ff <= ev.taken && want_tgt;
            if (want_opnd) begin
              state_ff <= S_MARK;
            end else if (ev.taken && want_tgt) begin
              state_ff <= S_AMRK;
            end
            if (want_opnd) begin
              fmt_payload <= ev.taken ? ST_TAKEN : ST_INSN;
            end
            // Marker value is latched now, sent next cycle
            opnd_wr_ff <= ev.opnd_write;
            data_left_ff <= size_nibbles(ev.opnd_size);
            addr_left_ff <= 3'h0;
            if (want_opnd) begin
              opnd_ff <= ev.opnd_data;
            end
            if (want_opnd) begin
              addr_left_ff <= {1'b0, ev.opnd_size};
            end
          end
        end
        S_MARK: begin
          // Operand size marker follows the status entry
          fmt_kind <= 2'h0;
          fmt_payload <= size_marker(bte_size_t'(addr_left_ff[1:0]));
          entry_valid_ff <= 1'b1;
          state_ff <= S_DATA;
        end
        S_DATA: begin
          fmt_kind <= 2'h1;
          fmt_payload <= {opnd_wr_ff, opnd_ff[3:0]};
          entry_valid_ff <= 1'b1;
          opnd_ff <= {4'h0, opnd_ff[31:4]};
          data_left_ff <= data_left_ff - 4'h1;
          if (data_left_ff == 4'h1) begin
            state_ff <= do_addr_ff ? S_AMRK : S_IDLE;
          end
        end
        S_AMRK: begin
          fmt_kind <= 2'h0;
          fmt_payload <= cfg.tgt_3byte ? ST_ADDR_3B : ST_ADDR_2B;
          entry_valid_ff <= 1'b1;
          addr_left_ff <= cfg.tgt_3byte ? 3'h6 : 3'h4;
          state_ff <= S_ADDR;
        end
        S_ADDR: begin
          fmt_kind <= 2'h2;
          fmt_payload <= {1'b0, addr_ff[3:0]};
          entry_valid_ff <= 1'b1;
          addr_ff <= {4'h0, addr_ff[22:4]};
          addr_left_ff <= addr_left_ff - 3'h1;
          if (addr_left_ff == 3'h1) begin
            state_ff <= S_IDLE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Exception copy counter; cleared once the vector branch is issued
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      excp_cnt_ff <= 2'h0;
    end else if (state_ff == S_IDLE) begin
      if (excp) begin
        if (excp_cnt_ff < EXCP_COPIES) begin
          excp_cnt_ff <= excp_cnt_ff + 2'h1;
        end else if (excp_cnt_ff == EXCP_COPIES) begin
          excp_cnt_ff <= EXCP_COPIES;
        end
      end else begin
        excp_cnt_ff <= 2'h0;
      end
    end
  end

  // ==========================================================================
  // Entry formatting; output register keeps entries in issue order
  bte_entry_fmt u_fmt (
    .kind(fmt_kind),
    .payload(fmt_payload),
    .entry(fmt_entry)
  );

  assign entry_data_ff = fmt_entry;

  // ==========================================================================
  // Checks
  sequence s_taken_mark;
    entry_valid_ff && entry_data_ff == {1'b0, ST_TAKEN} && state_ff == S_AMRK;
  endsequence

  property p_mark_after_taken;
    @(posedge clk) disable iff (!resetn)
    s_taken_mark |=> entry_valid_ff && entry_data_ff[5] == 1'b0 &&
      (entry_data_ff[4:0] == ST_ADDR_2B || entry_data_ff[4:0] == ST_ADDR_3B);
  endproperty
  a_mark_after_taken: assert property (p_mark_after_taken) else $error("marker missing after taken");

  property p_addr_count;
    @(posedge clk) disable iff (!resetn)
    (state_ff == S_AMRK && !cfg.tgt_3byte) |=> (state_ff == S_ADDR)[*4] ##1 state_ff != S_ADDR;
  endproperty
  a_addr_count: assert property (p_addr_count) else $error("wrong address entry count");

  property p_addr_prefix;
    @(posedge clk) disable iff (!resetn)
    (state_ff == S_ADDR) |=> entry_valid_ff && entry_data_ff[5:4] == ADDR_PREFIX;
  endproperty
  a_addr_prefix: assert property (p_addr_prefix) else $error("address entry prefix wrong");

  property p_data_bit;
    @(posedge clk) disable iff (!resetn)
    (state_ff == S_DATA) |=> entry_valid_ff && entry_data_ff[5] && entry_data_ff[4] == $past(opnd_wr_ff);
  endproperty
  a_data_bit: assert property (p_data_bit) else $error("data entry format wrong");

  property p_excp_limit;
    @(posedge clk) disable iff (!resetn)
    excp_cnt_ff == EXCP_COPIES && excp && state_ff == S_IDLE |=> !entry_valid_ff;
  endproperty
  a_excp_limit: assert property (p_excp_limit) else $error("extra exception entry");

  property p_no_tgt_disabled;
    @(posedge clk) disable iff (!resetn)
    (state_ff == S_IDLE && ev_valid && ev_ready && !cfg.tgt_en && !want_opnd) |=> state_ff == S_IDLE;
  endproperty
  a_no_tgt_disabled: assert property (p_no_tgt_disabled) else $error("target sent while disabled");

  property p_insn_code;
    @(posedge clk) disable iff (!resetn)
    (ev_valid && ev_ready && !ev.taken) |=> entry_valid_ff && entry_data_ff == {1'b0, ST_INSN};
  endproperty
  a_insn_code: assert property (p_insn_code) else $error("instruction code wrong");

  property p_taken_code;
    @(posedge clk) disable iff (!resetn)
    (ev_valid && ev_ready && ev.taken) |=> entry_valid_ff && entry_data_ff == {1'b0, ST_TAKEN};
  endproperty
  a_taken_code: assert property (p_taken_code) else $error("taken code wrong");
endmodule // bte_encoder

//--- dv/bte_core_model.sv
// Core-side model: presents retirement events and holds each one until accepted.
// Assumes ev_ready has settled by a short delay after each rising clock edge.
module bte_core_model (
  input wire logic clk,
  input wire logic ev_ready,
  output logic ev_valid,
  output bte_pkg::bte_event_t ev
);
  timeunit 1ns;
  timeprecision 1ps;
  import bte_pkg::*;
  // ==========================================================================
  // Idle bus shows the inverse of the last event, never a stale copy
  initial begin
    ev_valid = 1'b0;
    ev = '1;
  end
  // Hold the event until the edge that sees ev_ready high
  task automatic send(input bte_event_t e);
    int n;
    n = 0;
    ev_valid = 1'b1;
    ev = e;
    while (ev_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
  endtask
  // Separate release so back-to-back sends never toggle valid in one step
  task automatic idle_bus();
    ev_valid = 1'b0;
    ev = ~ev;
  endtask
endmodule // bte_core_model

//--- dv/testbench.sv
// Self-checking bench for the trace encoder: scenario tasks, entry collector, verdict.
// Assumes bte_core_model feeds events; config and exceptions driven here.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bte_pkg::*;
  logic clk, resetn, excp, ev_valid, ev_ready, entry_valid_ff;
  bte_cfg_t cfg;
  bte_event_t ev;
  logic [23:0] excp_vector;
  logic [5:0] entry_data_ff;
  int error_cnt, checks_done, cyc;
  logic [5:0] got[$], exp[$];
  // ==========================================================================
  // Clock, design and core model
  initial clk = 1'b0;
  always #10 clk = ~clk;
  bte_encoder dut_u (.clk(clk), .resetn(resetn), .cfg(cfg), .ev_valid(ev_valid), .ev(ev), .excp(excp),
    .excp_vector(excp_vector), .ev_ready(ev_ready), .entry_data_ff(entry_data_ff),
    .entry_valid_ff(entry_valid_ff));
  bte_core_model core_u (.clk(clk), .ev_ready(ev_ready), .ev_valid(ev_valid), .ev(ev));
  // Every entry lands in the queue in arrival order
  // Sampled mid-cycle, where the registered entry has long settled
  always @(negedge clk) if (entry_valid_ff === 1'b1) got.push_back(entry_data_ff);
  // Hang guard, well above the longest scenario
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ==========================================================================
  // Helpers
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] expd);
    checks_done++;
    if (seen !== expd) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", name, expd, seen);
    end
  endtask
  function automatic logic [5:0] st(logic [4:0] c);
    return {1'b0, c};
  endfunction
  // Nibble entries under a 2-bit prefix, least significant first
  task automatic nibs(logic [1:0] pfx, logic [31:0] v, int n);
    for (int i = 0; i < n; i++) exp.push_back({pfx, v[4*i+:4]});
  endtask
  // Wait for the encoder to go idle, with a bounded count
  task automatic settle();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (ev_ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic cmp_q(string name);
    check({name, " count"}, got.size(), exp.size());
    foreach (exp[i]) if (i < got.size()) check(name, got[i], exp[i]);
    got.delete();
    exp.delete();
  endtask
  function automatic bte_event_t mk(logic tk, logic vr, logic ov, logic ow, bte_size_t sz, logic [31:0] d,
      logic [23:0] t);
    return '{tk, vr, ov, ow, sz, d, t};
  endfunction
  task automatic run(bte_event_t e);
    core_u.send(e);
    core_u.idle_bus();
    settle();
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_plain();
    cfg = '{1'b1, 1'b1, 1'b1, 1'b0};
    run(mk(0, 0, 0, 0, BTE_SZ_1, 32'h0000_0000, 24'h00_0000));
    exp = {st(ST_INSN)};
    cmp_q("plain insn");
  endtask
  task automatic t_byte();
    cfg = '{1'b1, 1'b1, 1'b0, 1'b0};
    run(mk(0, 0, 1, 1, BTE_SZ_1, 32'h0000_0000, 24'h00_0000));
    exp = {st(ST_INSN), st(ST_OPND_1B)};
    nibs(2'b11, 32'h0000_0000, 2);
    cmp_q("byte write");
    run(mk(0, 0, 1, 0, BTE_SZ_1, 32'h0000_0018, 24'h00_0000));
    exp = {st(ST_INSN), st(ST_OPND_1B)};
    nibs(2'b10, 32'h0000_0018, 2);
    cmp_q("byte read");
    cfg = '{1'b1, 1'b0, 1'b0, 1'b0};
    run(mk(0, 0, 1, 1, BTE_SZ_1, 32'h0000_00a5, 24'h00_0000));
    exp = {st(ST_INSN)};
    cmp_q("untraced write");
  endtask
  task automatic t_wide();
    cfg = '{1'b1, 1'b1, 1'b0, 1'b0};
    run(mk(0, 0, 1, 0, BTE_SZ_2, 32'h0000_beef, 24'h00_0000));
    exp = {st(ST_INSN), st(ST_OPND_2B)};
    nibs(2'b10, 32'h0000_beef, 4);
    cmp_q("word read");
    run(mk(0, 0, 1, 1, BTE_SZ_4, 32'h1234_5678, 24'h00_0000));
    exp = {st(ST_INSN), st(ST_OPND_4B)};
    nibs(2'b11, 32'h1234_5678, 8);
    cmp_q("long write");
  endtask
  task automatic t_target();
    cfg = '{1'b0, 1'b0, 1'b1, 1'b0};
    run(mk(1, 1, 0, 0, BTE_SZ_1, 32'h0000_0000, 24'h00_1074));
    exp = {st(ST_TAKEN), st(ST_ADDR_2B)};
    nibs(2'b10, 32'h0000_083a, 4);
    cmp_q("target 2b");
    cfg = '{1'b0, 1'b0, 1'b1, 1'b1};
    run(mk(1, 1, 0, 0, BTE_SZ_1, 32'h0000_0000, 24'hab_cdef));
    exp = {st(ST_TAKEN), st(ST_ADDR_3B)};
    nibs(2'b10, 32'h0055_e6f7, 6);
    cmp_q("target 3b");
    run(mk(1, 0, 0, 0, BTE_SZ_1, 32'h0000_0000, 24'h00_2222));
    exp = {st(ST_TAKEN)};
    cmp_q("fixed branch");
    cfg = '{1'b0, 1'b0, 1'b0, 1'b0};
    run(mk(1, 1, 0, 0, BTE_SZ_1, 32'h0000_0000, 24'h00_4444));
    exp = {st(ST_TAKEN)};
    cmp_q("capture off");
  endtask
  // Second event queued while the first still emits its address
  task automatic t_b2b();
    cfg = '{1'b0, 1'b0, 1'b1, 1'b0};
    core_u.send(mk(1, 1, 0, 0, BTE_SZ_1, 32'h0000_0000, 24'h00_5432));
    core_u.send(mk(0, 0, 0, 0, BTE_SZ_1, 32'h0000_0000, 24'h00_0000));
    core_u.idle_bus();
    settle();
    exp = {st(ST_TAKEN), st(ST_ADDR_2B)};
    nibs(2'b10, 32'h0000_2a19, 4);
    exp.push_back(st(ST_INSN));
    cmp_q("back to back");
  endtask
  // Long exception mode: only two copies, then handler address
  task automatic t_excp();
    cfg = '{1'b0, 1'b0, 1'b1, 1'b0};
    excp = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    excp = 1'b0;
    excp_vector = 24'h00_1074;
    check("ready on vector", ev_ready, 32'h0000_0000);
    @(posedge clk);
    #1;
    excp_vector = ~excp_vector;
    settle();
    exp = {st(ST_EXCP), st(ST_EXCP), st(ST_TAKEN), st(ST_ADDR_2B)};
    nibs(2'b10, 32'h0000_083a, 4);
    cmp_q("exception");
    // Short exception with capture off: one copy, then the bare taken code
    cfg = '{1'b0, 1'b0, 1'b0, 1'b0};
    excp = 1'b1;
    @(posedge clk);
    #1;
    excp = 1'b0;
    check("ready on bare vector", ev_ready, 32'h0000_0000);
    settle();
    exp = {st(ST_EXCP), st(ST_TAKEN)};
    cmp_q("exception no capture");
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    excp = 1'b0;
    excp_vector = '0;
    cfg = '0;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_plain();
    t_byte();
    t_wide();
    t_target();
    t_b2b();
    t_excp();
    end_sim();
  end
endmodule // testbench
